// ==== include/urxbg_pkg.sv ====
// Constants, types and register map of the receive filter and baud generator
package urxbg_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned URXBG_PRS_W = 3;
    localparam int unsigned URXBG_DIV_W = 12;
    localparam int unsigned URXBG_PRE_W = 7;
    localparam int unsigned URXBG_IDX_W = 22;
    localparam int unsigned URXBG_CHR_W = 9;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [21:0] URXBG_IDX_MAIN = 22'h0f_0240;
    localparam logic [21:0] URXBG_IDX_BAUD0 = 22'h0f_0242;
    localparam logic [21:0] URXBG_IDX_BAUD1 = 22'h0f_0262;
    localparam logic [21:0] URXBG_IDX_STAT = 22'h0f_0244;
    localparam logic [21:0] URXBG_IDX_MATCH = 22'h0f_0245;
    localparam logic [21:0] URXBG_IDX_RXD = 22'h0f_0246;
    localparam logic [21:0] URXBG_IDX_TXD = 22'h0f_0247;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] URXBG_BAUD_RST = 16'h0fff;
    localparam logic [9:0] URXBG_MAIN_RST = 10'h000;
    localparam logic [7:0] URXBG_MATCH_RST = 8'h00;
    localparam int unsigned URXBG_PRS_LSB = 13;
    localparam logic [11:0] URXBG_K_MIN = 12'h004;
    localparam logic [1:0] URXBG_MODE_AUTO = 2'b11;
    localparam logic [3:0] URXBG_SEL_HALF = 4'h3;

    // Main control bit positions
    localparam int unsigned URXBG_B_PER = 0;
    localparam int unsigned URXBG_B_TXE = 1;
    localparam int unsigned URXBG_B_RXE = 2;
    localparam int unsigned URXBG_B_MD0 = 3;
    localparam int unsigned URXBG_B_MD1 = 4;
    localparam int unsigned URXBG_B_CL = 5;
    localparam int unsigned URXBG_B_EBE = 6;
    localparam int unsigned URXBG_B_EBC = 7;
    localparam int unsigned URXBG_B_EBL = 8;
    localparam int unsigned URXBG_B_FLB = 9;

    // Status bit positions (write one to clear)
    localparam int unsigned URXBG_S_EBD = 0;
    localparam int unsigned URXBG_S_IDM = 1;
    localparam int unsigned URXBG_S_FE = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        URXBG_RX_IDLE = 4'b0001,
        URXBG_RX_START = 4'b0010,
        URXBG_RX_DATA = 4'b0100,
        URXBG_RX_STOP = 4'b1000
    } urxbg_rx_e;

    typedef struct packed {
        logic [2:0] prescale_select;
        logic [11:0] divider_value;
    } urxbg_baud_s;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic filt_smp;
        logic filt_out;
        logic line_prev;
        logic [6:0] pre_cnt;
        logic [12:0] tx_cnt;
        logic [12:0] rx_cnt;
        urxbg_rx_e rx_state;
        logic [3:0] bit_idx;
        logic [8:0] shift;
        logic [9:0] main;
        urxbg_baud_s baud;
        logic [7:0] match_value;
        logic [8:0] rx_data;
        logic [2:0] flags;
        logic status_irq;
        logic done_irq;
        logic tx_tick;
        logic [8:0] tx_data;
        logic tx_start;
        logic ack;
        logic [31:0] rdat;
    } urxbg_state_s;

endpackage : urxbg_pkg

// ==== hdl/urxbg_top.sv ====
// Receive filter, expansion-bit receiver and baud rate generator
`timescale 1ns/1ns

module urxbg_top
    import urxbg_pkg::*;
#(
    parameter int unsigned CHANNEL = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [23:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic serial_input_pin_i,
    input wire logic [11:0] auto_divider_i,
    input wire logic auto_divider_valid_i,
    output logic [8:0] rx_data_o,
    output logic status_irq_o,
    output logic receive_done_irq_o,
    output logic [8:0] tx_data_o,
    output logic tx_start_o,
    output logic tx_bit_tick_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam logic [21:0] IDX_BAUD =
        (CHANNEL == 0) ? URXBG_IDX_BAUD0 : URXBG_IDX_BAUD1;

    urxbg_state_s s_r;
    urxbg_state_s s_nxt;

    logic en;
    logic txe;
    logic rxe;
    logic auto_md;
    logic ext_md;
    logic ptick;
    logic line;
    logic [6:0] mask;
    logic [11:0] kx;
    logic [12:0] kx2;
    logic [21:0] idx;
    logic req;
    logic [3:0] nbits;
    logic ext_bit;
    logic [7:0] low8;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.status_irq = 1'b0;
        s_nxt.done_irq = 1'b0;
        s_nxt.tx_tick = 1'b0;
        s_nxt.tx_start = 1'b0;

        en = s_r.main[URXBG_B_PER];
        txe = s_r.main[URXBG_B_TXE];
        rxe = s_r.main[URXBG_B_RXE];
        auto_md = ({s_r.main[URXBG_B_MD1], s_r.main[URXBG_B_MD0]}
            == URXBG_MODE_AUTO);
        ext_md = s_r.main[URXBG_B_CL] & s_r.main[URXBG_B_EBE];
        nbits = ext_md ? 4'h9 : 4'h8;

        // Synchroniser: first stage feeds only the second
        s_nxt.sync1 = serial_input_pin_i;
        s_nxt.sync2 = s_r.sync1;

        // Prescaler: ticks when its low select bits are all ones
        mask = 7'h7f >> (3'd7 - s_r.baud.prescale_select);
        ptick = en && ((s_r.pre_cnt & mask) == mask);
        s_nxt.pre_cnt = en ? s_r.pre_cnt + 7'h01 : 7'h00;

        // Two equal prescaled samples move the filter output
        if (ptick) begin
            s_nxt.filt_smp = s_r.sync2;
            if (s_r.sync2 == s_r.filt_smp) begin
                s_nxt.filt_out = s_r.sync2;
            end
        end
        line = s_r.main[URXBG_B_FLB] ? s_r.sync2 : s_r.filt_out;
        s_nxt.line_prev = line;

        // Factor k clamped; one bit is 2k ticks
        kx = (s_r.baud.divider_value < URXBG_K_MIN) ? URXBG_K_MIN
            : s_r.baud.divider_value;
        kx2 = {kx, 1'b0};

        // Transmit divider
        if (!en || !txe) begin
            s_nxt.tx_cnt = 13'h0000;
        end else if (ptick) begin
            if (s_r.tx_cnt == kx2 - 13'h0001) begin
                s_nxt.tx_cnt = 13'h0000;
                s_nxt.tx_tick = 1'b1;
            end else begin
                s_nxt.tx_cnt = s_r.tx_cnt + 13'h0001;
            end
        end

        // Register bus; clears happen before receive events so sets win
        idx = adr_i[23:2];
        req = cyc_i & stb_i & ~s_r.ack;
        s_nxt.ack = req;
        if (req) begin
            s_nxt.rdat = 32'h0000_0000;
            unique case (idx)
                URXBG_IDX_MAIN: begin
                    s_nxt.rdat[9:0] = s_r.main;
                    if (we_i) begin
                        s_nxt.main = dat_i[9:0];
                    end
                end
                IDX_BAUD: begin
                    s_nxt.rdat[15:0] = {s_r.baud.prescale_select, 1'b0,
                        s_r.baud.divider_value};
                    // Only a full 16-bit write lands
                    if (we_i && (sel_i[1:0] == URXBG_SEL_HALF[1:0])) begin
                        s_nxt.baud.prescale_select =
                            dat_i[URXBG_PRS_LSB +: 3];
                        if (!auto_md) begin
                            s_nxt.baud.divider_value = dat_i[11:0];
                        end
                    end
                end
                URXBG_IDX_STAT: begin
                    s_nxt.rdat[2:0] = s_r.flags;
                    if (we_i) begin
                        s_nxt.flags = s_r.flags & ~dat_i[2:0];
                    end
                end
                URXBG_IDX_MATCH: begin
                    s_nxt.rdat[7:0] = s_r.match_value;
                    if (we_i) begin
                        s_nxt.match_value = dat_i[7:0];
                    end
                end
                URXBG_IDX_RXD: begin
                    s_nxt.rdat[8:0] = s_r.rx_data;
                end
                URXBG_IDX_TXD: begin
                    s_nxt.rdat[8:0] = s_r.tx_data;
                    if (we_i) begin
                        s_nxt.tx_data = ext_md ? dat_i[8:0]
                            : {1'b0, dat_i[7:0]};
                        s_nxt.tx_start = 1'b1;
                    end
                end
                default: begin
                    s_nxt.rdat = 32'h0000_0000;
                end
            endcase
        end

        // Hardware-measured factor replaces the divider in automatic mode
        if (auto_md && auto_divider_valid_i) begin
            s_nxt.baud.divider_value = auto_divider_i;
        end

        // Received character fields
        ext_bit = s_r.shift[8];
        low8 = ext_md ? s_r.shift[7:0] : s_r.shift[8:1];

        // Receiver
        if (!en || !rxe) begin
            s_nxt.rx_state = URXBG_RX_IDLE;
            s_nxt.rx_cnt = 13'h0000;
        end else begin
            unique case (s_r.rx_state)
                URXBG_RX_IDLE: begin
                    if (s_r.line_prev && !line) begin
                        s_nxt.rx_cnt = 13'h0000;
                        s_nxt.rx_state = URXBG_RX_START;
                    end
                end
                URXBG_RX_START: begin
                    if (ptick) begin
                        s_nxt.rx_cnt = s_r.rx_cnt + 13'h0001;
                        // Mid start bit: a high line was a glitch
                        if (s_r.rx_cnt == {1'b0, kx} - 13'h0001) begin
                            s_nxt.rx_cnt = 13'h0000;
                            s_nxt.bit_idx = 4'h0;
                            s_nxt.rx_state = line ? URXBG_RX_IDLE
                                : URXBG_RX_DATA;
                        end
                    end
                end
                URXBG_RX_DATA: begin
                    if (ptick) begin
                        s_nxt.rx_cnt = s_r.rx_cnt + 13'h0001;
                        if (s_r.rx_cnt == kx2 - 13'h0001) begin
                            s_nxt.rx_cnt = 13'h0000;
                            s_nxt.shift = {line, s_r.shift[8:1]};
                            s_nxt.bit_idx = s_r.bit_idx + 4'h1;
                            if (s_r.bit_idx == nbits - 4'h1) begin
                                s_nxt.rx_state = URXBG_RX_STOP;
                            end
                        end
                    end
                end
                URXBG_RX_STOP: begin
                    if (ptick) begin
                        s_nxt.rx_cnt = s_r.rx_cnt + 13'h0001;
                        if (s_r.rx_cnt == kx2 - 13'h0001) begin
                            s_nxt.rx_cnt = 13'h0000;
                            s_nxt.rx_state = URXBG_RX_IDLE;
                            if (!line) begin
                                // Framing error takes the status path
                                s_nxt.flags[URXBG_S_FE] = 1'b1;
                                s_nxt.status_irq = 1'b1;
                            end else if (!ext_md) begin
                                s_nxt.rx_data = {1'b0, low8};
                                s_nxt.done_irq = 1'b1;
                            end else if (s_r.main[URXBG_B_EBC]) begin
                                if ((ext_bit == s_r.main[URXBG_B_EBL])
                                    && (low8 == s_r.match_value)) begin
                                    s_nxt.rx_data = s_r.shift;
                                    s_nxt.flags[URXBG_S_IDM] = 1'b1;
                                    s_nxt.flags[URXBG_S_EBD] = 1'b1;
                                    s_nxt.status_irq = 1'b1;
                                end
                                // Mismatch leaves everything as is
                            end else begin
                                s_nxt.rx_data = s_r.shift;
                                if (ext_bit == s_r.main[URXBG_B_EBL]) begin
                                    s_nxt.flags[URXBG_S_EBD] = 1'b1;
                                    s_nxt.status_irq = 1'b1;
                                end else begin
                                    s_nxt.done_irq = 1'b1;
                                end
                            end
                        end
                    end
                end
            endcase
        end

        if (rst_i) begin
            s_nxt = '0;
            s_nxt.sync1 = 1'b1;
            s_nxt.sync2 = 1'b1;
            s_nxt.filt_smp = 1'b1;
            s_nxt.filt_out = 1'b1;
            s_nxt.line_prev = 1'b1;
            s_nxt.rx_state = URXBG_RX_IDLE;
            s_nxt.main = URXBG_MAIN_RST;
            s_nxt.match_value = URXBG_MATCH_RST;
            s_nxt.baud = urxbg_baud_s'({URXBG_BAUD_RST[15:13],
                URXBG_BAUD_RST[11:0]});
        end
    end

    // ------------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign dat_o = s_r.rdat;
    assign ack_o = s_r.ack;
    assign rx_data_o = s_r.rx_data;
    assign status_irq_o = s_r.status_irq;
    assign receive_done_irq_o = s_r.done_irq;
    assign tx_data_o = s_r.tx_data;
    assign tx_start_o = s_r.tx_start;
    assign tx_bit_tick_o = s_r.tx_tick;

endmodule : urxbg_top

// ==== testbench/urxbg_chk.sv ====
// Port checker for the receive filter and baud generator
`timescale 1ns/1ns
module urxbg_chk
    import urxbg_pkg::*;
#(
    parameter int unsigned CHANNEL = 0
) (
    input logic clk_i,
    input logic rst_i,
    input logic [23:0] adr_i,
    input logic [31:0] dat_i,
    input logic [31:0] dat_o,
    input logic we_i,
    input logic [3:0] sel_i,
    input logic cyc_i,
    input logic stb_i,
    input logic ack_o,
    input logic serial_input_pin_i,
    input logic [11:0] auto_divider_i,
    input logic auto_divider_valid_i,
    input logic [8:0] rx_data_o,
    input logic status_irq_o,
    input logic receive_done_irq_o,
    input logic [8:0] tx_data_o,
    input logic tx_start_o,
    input logic tx_bit_tick_o
);
    // ------------------------------------------------------------------
    // Bus and event relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic mapped;
    assign mapped = adr_i[23:2] inside {URXBG_IDX_MAIN, URXBG_IDX_BAUD0,
        URXBG_IDX_BAUD1, URXBG_IDX_STAT, URXBG_IDX_MATCH, URXBG_IDX_RXD,
        URXBG_IDX_TXD};
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_tx_write;
        s_take ##0 (we_i && adr_i[23:2] == URXBG_IDX_TXD);
    endsequence
    chk_ack_after_take: assert property (s_take |=> ack_o)
        else $error("request not acknowledged in one cycle");
    chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    chk_ack_no_request: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("acknowledge without request");
    chk_unmapped_zero: assert property (s_take ##0 (!we_i && !mapped)
        |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Shortest bit is k of 4 at no prescale, so eight clocks apart
    chk_tick_min_gap: assert property (tx_bit_tick_o
        |=> !tx_bit_tick_o [*7])
        else $error("bit ticks closer than eight clocks");
    chk_status_pulse: assert property (status_irq_o |=> !status_irq_o)
        else $error("status interrupt longer than one cycle");
    chk_done_pulse: assert property (receive_done_irq_o
        |=> !receive_done_irq_o)
        else $error("receive interrupt longer than one cycle");
    chk_irq_apart: assert property (!(status_irq_o && receive_done_irq_o))
        else $error("both interrupts at once");
    chk_store_with_irq: assert property (!$stable(rx_data_o)
        |-> status_irq_o || receive_done_irq_o)
        else $error("receive data changed without interrupt");
    chk_tx_start_write: assert property (s_tx_write |=> ##[0:1] tx_start_o)
        else $error("transmit write gave no start pulse");
endmodule : urxbg_chk

bind urxbg_top urxbg_chk #(.CHANNEL(CHANNEL)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .serial_input_pin_i(serial_input_pin_i), .auto_divider_i(auto_divider_i),
    .auto_divider_valid_i(auto_divider_valid_i), .rx_data_o(rx_data_o),
    .status_irq_o(status_irq_o), .receive_done_irq_o(receive_done_irq_o),
    .tx_data_o(tx_data_o), .tx_start_o(tx_start_o),
    .tx_bit_tick_o(tx_bit_tick_o));

// ==== testbench/urxbg_line_model.sv ====
// Remote serial node that sends frames, optionally with short glitches
`timescale 1ns/1ns
module urxbg_line_model (
    input wire logic clk_i,
    output logic line_o
);
    initial line_o = 1'b1; // Line idles high before any enable
    // Glitches last two clocks, one tick at prescale one, off bit edges
    task automatic send(input logic [8:0] d, input int nb, input int bc,
            input bit noisy);
        logic v;
        for (int b = 0; b < nb + 2; b++) begin
            v = (b == 0) ? 1'b0 : (b == nb + 1) ? 1'b1 : d[b-1];
            for (int c = 0; c < bc; c++) begin
                @(posedge clk_i);
                line_o <= (noisy && c >= bc / 4 && c < bc - bc / 8 &&
                    (c % (bc / 4)) < 2) ? ~v : v;
            end
        end
        repeat (3 * bc) @(posedge clk_i);
    endtask : send
endmodule : urxbg_line_model

// ==== testbench/test_uart_rx_filter_baud_gen.sv ====
// Self-checking bench for the receive filter and baud generator
`timescale 1ns/1ns
module test_uart_rx_filter_baud_gen;
    import urxbg_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0;
    logic stb_i = 1'b0, auto_divider_valid_i = 1'b0;
    logic [23:0] adr_i = '0;
    logic [31:0] dat_i = '0, dat_o;
    logic [3:0] sel_i = '0;
    logic [11:0] auto_divider_i = '0;
    logic ack_o, status_irq_o, receive_done_irq_o, tx_start_o, tx_bit_tick_o;
    logic [8:0] rx_data_o, tx_data_o;
    logic line;
    int n_mismatch = 0, total_checks = 0, cycles = 0, n_start = 0;
    logic [3:0] wsel = 4'hf;
    logic [31:0] rd_q[$];
    logic [9:0] rx_q[$];

    urxbg_top #(.CHANNEL(0)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .serial_input_pin_i(line), .auto_divider_i(auto_divider_i),
        .auto_divider_valid_i(auto_divider_valid_i), .rx_data_o(rx_data_o),
        .status_irq_o(status_irq_o), .receive_done_irq_o(receive_done_irq_o),
        .tx_data_o(tx_data_o), .tx_start_o(tx_start_o),
        .tx_bit_tick_o(tx_bit_tick_o));
    urxbg_line_model u_line (.clk_i(clk_i), .line_o(line));

    initial forever #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Each result is matched against the oldest note; stray irqs fail
    always @(posedge clk_i) begin
        cycles++;
        if (tx_start_o === 1'b1) begin
            n_start++;
        end
        if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) begin
            check(dat_o, rd_q.pop_front());
        end
        if (status_irq_o === 1'b1 || receive_done_irq_o === 1'b1) begin
            if (rx_q.size() == 0) begin
                check({22'h0, status_irq_o, rx_data_o}, 32'hffff_ffff);
            end else begin
                check({22'h0, status_irq_o, rx_data_o}, {22'h0, rx_q.pop_front()});
            end
        end
        if (cycles == 80000) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Bus and timing tasks
    // ------------------------------------------------------------------
    task automatic wb(input logic [21:0] idx, input logic we,
            input logic [31:0] d);
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        we_i <= we;
        sel_i <= wsel;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [21:0] idx, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(idx, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        do @(posedge clk_i); while (tx_bit_tick_o !== 1'b1);
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_bit_tick_o !== 1'b1);
        check(n, exp);
    endtask : tick_gap

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [2:0] p;
        logic [11:0] v;
        logic [8:0] d;
        int k;
        void'($urandom(34163));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(URXBG_IDX_BAUD0, {16'h0000, URXBG_BAUD_RST});
        // A byte-wide write must leave the whole word untouched
        wsel = 4'h1;
        wb(URXBG_IDX_BAUD0, 1'b1, 32'h0000_e001);
        wsel = 4'hf;
        rd(URXBG_IDX_BAUD0, {16'h0000, URXBG_BAUD_RST});
        wb(22'h0f_0300, 1'b1, 32'h0000_ffff);
        rd(22'h0f_0300, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            p = i[2:0];
            v = 12'($urandom_range(7, 0));
            k = (v < 4) ? 4 : int'(v);
            wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0000);
            wb(URXBG_IDX_BAUD0, 1'b1, {16'h0000, p, 1'b1, v});
            rd(URXBG_IDX_BAUD0, {16'h0000, p, 1'b0, v});
            wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0003);
            tick_gap(2 * k * (1 << i));
        end
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0000);
        k = 0;
        repeat (300) begin
            @(posedge clk_i);
            k += (tx_bit_tick_o === 1'b1) ? 1 : 0;
        end
        check(k, 0);
        // Automatic mode keeps the divider but still takes the prescaler
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0018);
        wb(URXBG_IDX_BAUD0, 1'b1, 32'h0000_4123);
        rd(URXBG_IDX_BAUD0, {16'h0000, 3'b010, 1'b0, v});
        auto_divider_i <= 12'($urandom());
        auto_divider_valid_i <= 1'b1;
        @(posedge clk_i);
        auto_divider_valid_i <= 1'b0;
        rd(URXBG_IDX_BAUD0, {16'h0000, 3'b010, 1'b0, auto_divider_i});
        // Prescale one, k of eight: one bit is thirty-two clocks
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0000);
        wb(URXBG_IDX_BAUD0, 1'b1, 32'h0000_2008);
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0005);
        d = 9'($urandom_range(255, 0));
        rx_q.push_back({2'b00, d[7:0]});
        u_line.send(d, 8, 32, 1'b1);
        wb(URXBG_IDX_MATCH, 1'b1, {24'h0, d[7:0]});
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_01e5);
        u_line.send({1'b1, ~d[7:0]}, 9, 32, 1'b0);
        rd(URXBG_IDX_STAT, 32'h0000_0000);
        rx_q.push_back({2'b11, d[7:0]});
        u_line.send({1'b1, d[7:0]}, 9, 32, 1'b0);
        rd(URXBG_IDX_STAT, 32'h0000_0003);
        wb(URXBG_IDX_STAT, 1'b1, 32'h0000_0003);
        wb(URXBG_IDX_MAIN, 1'b1, 32'h0000_0365);
        rx_q.push_back({2'b00, ~d[7:0]});
        u_line.send({1'b0, ~d[7:0]}, 9, 32, 1'b0);
        rx_q.push_back({2'b11, d[7:0]});
        u_line.send({1'b1, d[7:0]}, 9, 32, 1'b0);
        wb(URXBG_IDX_TXD, 1'b1, {23'h0, 1'b1, d[7:0]});
        check({23'h0, tx_data_o}, {23'h0, 1'b1, d[7:0]});
        repeat (20) @(posedge clk_i);
        check(rx_q.size() + rd_q.size(), 0);
        check(n_start, 1);
        results();
    end
endmodule : test_uart_rx_filter_baud_gen
